// ---- rtl/fid_decoder.sv ----
/*
 * Instruction decoder for a 14-bit word core. Decodes each word once per
 * instruction cycle of four oscillator periods and holds the control
 * bundle, resolves skips and inserts the idle second cycle.
 * Assumes a fetched word valid during the first phase and the datapath
 * returning the result zero flag and operand bit during the last phase.
 */
// Summary of operation
// - byte ops: dest bit 0 writes accumulator (nothing for field 0000), 1 writes file register
// - byte field 0111 adds accumulator and file, updates carry, nibble carry, zero
// - fields 0101, 0100, 0110 are and, or, xor; zero flag only
// - 1011 decrements, 1111 increments; zero result skips next instruction
// - 1101 rotates left, 1100 rotates right through carry; carry only
// - byte 0010 file minus accumulator, literal 110x literal minus accumulator; all flags
// - bit words 00bb clear, 01bb set selected bit; no flags
// - bit words 10bb skip if clear, 11bb skip if set; two cycles when the skip is taken
// - literal 111x adds literal to accumulator; all flags
// - literal 1000, 1001, 1010 or, and, xor into accumulator; zero flag only
// - literal 00xx loads accumulator; 01xx loads and returns in two cycles
// - pc change or true test takes two cycles, second one idle
// - standby and watchdog-clear words are single cycle, touch expiry and powerdown flags
// - port read-modify-write uses sampled pin levels as operand
// - timer-zero count write clears prescaler when assigned to timer zero
// - seven-bit file address selects 0x00 to 0x7f in current bank
// - each instruction cycle spans four oscillator periods
`default_nettype none
`include "fid_map.svh"
module fid_decoder
(
   input  wire logic         clk_sys,
   input  wire logic         reset,
   input  wire logic [13:0]  instr_word,
   input  wire logic         result_zero,
   input  wire logic         tested_bit,
   input  wire logic         psc_on_timer,
   output fid_pkg::fid_ctl_t ctl,
   output logic              ctl_valid,
   output logic [1:0]        phase,
   output logic              cycle_end,
   output logic              idle_cycle
);
   logic [1:0]        phase_r, phase_nxt;
   fid_pkg::fid_ctl_t ctl_r, ctl_nxt;
   logic              valid_r, valid_nxt;
   logic              idle_r, idle_nxt;
   logic              fetch, last;
   logic              skip;

   // port registers share pin read-back
   function automatic logic is_port(input logic [6:0] a);
      is_port = (a >= `FID_ADDR_PORT_LO) && (a <= `FID_ADDR_PORT_HI);
   endfunction

   // full combinational decode of one word
   function automatic fid_pkg::fid_ctl_t decode(input logic [13:0] w, input logic psc_tmr);
      fid_pkg::fid_ctl_t c;
      logic [3:0] op;
      logic       d;
      c = '0;
      op = w[`FID_W_OP_HI:`FID_W_OP_LO];
      d = w[`FID_W_DEST];
      c.file_addr = w[`FID_W_FILE_HI:0];
      c.bit_sel = w[`FID_W_BIT_HI:`FID_W_BIT_LO];
      c.target = w[10:0];
      case (w[`FID_W_TOP_HI:`FID_W_TOP_LO])
         `FID_TOP_BYTE:
         begin
            c.wr_acc = ~d;
            c.wr_file = d;
            case (op)
               `FID_OP_MISC:
               begin
                  c.wr_acc = 1'b0;
                  c.wr_file = d;
                  c.alu = fid_pkg::FID_ALU_PASSW;
                  if (!d)
                  begin
                     if (w == `FID_WORD_RET) c.ret = 1'b1;
                     else if (w == `FID_WORD_RETI) c.reti = 1'b1;
                     else if (w == `FID_WORD_SLEEP) c.sleep = 1'b1;
                     else if (w == `FID_WORD_WDTCLR) c.wdt_clr = 1'b1;
                     else if ((w & `FID_NOP_MASK) != `FID_NOP_WORD) c.illegal = 1'b1;
                  end
               end
               `FID_OP_CLR:
               begin
                  c.alu = fid_pkg::FID_ALU_ZERO;
                  c.flags.z = 1'b1;
               end
               `FID_OP_SUB:
               begin
                  c.alu = fid_pkg::FID_ALU_SUBFW;
                  c.flags = '{c: 1'b1, dc: 1'b1, z: 1'b1};
               end
               `FID_OP_DEC:   begin c.alu = fid_pkg::FID_ALU_DEC;  c.flags.z = 1'b1; end
               `FID_OP_OR:    begin c.alu = fid_pkg::FID_ALU_OR;   c.flags.z = 1'b1; end
               `FID_OP_AND:   begin c.alu = fid_pkg::FID_ALU_AND;  c.flags.z = 1'b1; end
               `FID_OP_XOR:   begin c.alu = fid_pkg::FID_ALU_XOR;  c.flags.z = 1'b1; end
               `FID_OP_ADD:
               begin
                  c.alu = fid_pkg::FID_ALU_ADD;
                  c.flags = '{c: 1'b1, dc: 1'b1, z: 1'b1};
               end
               `FID_OP_MOV:   begin c.alu = fid_pkg::FID_ALU_PASSF; c.flags.z = 1'b1; end
               `FID_OP_COM:   begin c.alu = fid_pkg::FID_ALU_COM;  c.flags.z = 1'b1; end
               `FID_OP_INC:   begin c.alu = fid_pkg::FID_ALU_INC;  c.flags.z = 1'b1; end
               `FID_OP_DECSZ: begin c.alu = fid_pkg::FID_ALU_DEC;  c.skip_zero = 1'b1; end
               `FID_OP_RR:    begin c.alu = fid_pkg::FID_ALU_RR;   c.flags.c = 1'b1; end
               `FID_OP_RL:    begin c.alu = fid_pkg::FID_ALU_RL;   c.flags.c = 1'b1; end
               `FID_OP_SWAP:  c.alu = fid_pkg::FID_ALU_SWAP;
               `FID_OP_INCSZ: begin c.alu = fid_pkg::FID_ALU_INC;  c.skip_zero = 1'b1; end
               default:       c.illegal = 1'b1;
            endcase
            c.pin_read = c.wr_file && is_port(c.file_addr) && (op != `FID_OP_MISC);
         end
         `FID_TOP_BIT:
         begin
            case (op[3:2])
               `FID_BIT_CLR: begin c.alu = fid_pkg::FID_ALU_BCLR; c.wr_file = 1'b1; end
               `FID_BIT_SET: begin c.alu = fid_pkg::FID_ALU_BSET; c.wr_file = 1'b1; end
               `FID_BIT_TSTC: c.skip_bclr = 1'b1;
               `FID_BIT_TSTS: c.skip_bset = 1'b1;
               default: c.illegal = 1'b1;
            endcase
            c.pin_read = c.wr_file && is_port(c.file_addr);
         end
         `FID_TOP_BRANCH:
         begin
            c.call = ~w[`FID_W_JMP_SEL];
            c.jump = w[`FID_W_JMP_SEL];
         end
         default:
         begin
            c.use_lit = 1'b1;
            c.wr_acc = 1'b1;
            c.flags.z = 1'b1;
            case (op)
               4'h0, 4'h1, 4'h2, 4'h3: begin c.alu = fid_pkg::FID_ALU_PASSF; c.flags.z = 1'b0; end
               4'h4, 4'h5, 4'h6, 4'h7:
               begin
                  c.alu = fid_pkg::FID_ALU_PASSF;
                  c.flags.z = 1'b0;
                  c.ret = 1'b1;
               end
               4'h8: c.alu = fid_pkg::FID_ALU_OR;
               4'h9: c.alu = fid_pkg::FID_ALU_AND;
               4'ha: c.alu = fid_pkg::FID_ALU_XOR;
               4'hc, 4'hd:
               begin
                  c.alu = fid_pkg::FID_ALU_SUBFW;
                  c.flags = '{c: 1'b1, dc: 1'b1, z: 1'b1};
               end
               4'he, 4'hf:
               begin
                  c.alu = fid_pkg::FID_ALU_ADD;
                  c.flags = '{c: 1'b1, dc: 1'b1, z: 1'b1};
               end
               default:
               begin
                  c.illegal = 1'b1;
                  c.wr_acc = 1'b0;
                  c.flags.z = 1'b0;
               end
            endcase
         end
      endcase
      c.psc_clr = c.wr_file && (c.file_addr == `FID_ADDR_TIMER_ZERO_COUNT) && psc_tmr;
      decode = c;
   endfunction

   assign fetch = (phase_r == 2'h0);
   assign last = (phase_r == `FID_PHASES);
   assign skip = (ctl_r.skip_zero && result_zero) || (ctl_r.skip_bclr && !tested_bit)
               || (ctl_r.skip_bset && tested_bit);

   // phase counter, decode latch and idle insertion
   always_comb
   begin
      phase_nxt = phase_r + 2'h1;
      ctl_nxt = ctl_r;
      valid_nxt = valid_r;
      idle_nxt = idle_r;
      if (fetch)
      begin
         valid_nxt = ~idle_r;
         ctl_nxt = idle_r ? '0 : decode(instr_word, psc_on_timer);
      end
      if (last)
         idle_nxt = valid_r && (skip || ctl_r.call || ctl_r.jump || ctl_r.ret || ctl_r.reti);
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         phase_r <= 2'h0;
         ctl_r <= '0;
         valid_r <= 1'b0;
         idle_r <= 1'b0;
      end
      else
      begin
         phase_r <= phase_nxt;
         ctl_r <= ctl_nxt;
         valid_r <= valid_nxt;
         idle_r <= idle_nxt;
      end
   end

   assign ctl = ctl_r;
   assign ctl_valid = valid_r;
   assign phase = phase_r;
   assign cycle_end = last;
   assign idle_cycle = ~valid_r;

   // checks
   phase_wrap_a: assert property (@(posedge clk_sys) disable iff (reset)
      last |=> phase_r == 2'h0) else $error("phase did not wrap");
   dest_acc_a: assert property (@(posedge clk_sys) disable iff (reset)
      fetch && instr_word[13:12] == 2'h0 && instr_word[11:8] != 4'h0 && !idle_r
      |=> ctl_r.wr_acc == !$past(instr_word[7])) else $error("destination wrong");
   add_flags_a: assert property (@(posedge clk_sys) disable iff (reset)
      fetch && !idle_r && instr_word[13:8] == 6'h07
      |=> ctl_r.alu == fid_pkg::FID_ALU_ADD && ctl_r.flags == 3'h7) else $error("add decode");
   logic_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
      fetch && !idle_r && instr_word[13:8] inside {6'h04, 6'h05, 6'h06}
      |=> ctl_r.flags == 3'h1) else $error("logic flags");
   skip_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
      last && valid_r && ctl_r.skip_zero && result_zero |=> ##3 !valid_r) else $error("no idle");
   branch_two_a: assert property (@(posedge clk_sys) disable iff (reset)
      last && valid_r && ctl_r.jump |=> ##3 !valid_r ##4 1) else $error("jump one cycle");
   single_cyc_a: assert property (@(posedge clk_sys) disable iff (reset)
      last && valid_r && (ctl_r.sleep || ctl_r.wdt_clr) |=> ##3 valid_r) else $error("extra idle");
   bit_noflag_a: assert property (@(posedge clk_sys) disable iff (reset)
      valid_r && ctl_r.alu inside {fid_pkg::FID_ALU_BCLR, fid_pkg::FID_ALU_BSET}
      |-> ctl_r.flags == 3'h0) else $error("bit op flags");
   psc_clr_a: assert property (@(posedge clk_sys) disable iff (reset)
      ctl_r.psc_clr |-> ctl_r.wr_file && ctl_r.file_addr == `FID_ADDR_TIMER_ZERO_COUNT) else $error("prescaler clear");
   skip_cov_c: cover property (@(posedge clk_sys) disable iff (reset) last && valid_r && skip);
   call_cov_c: cover property (@(posedge clk_sys) disable iff (reset) valid_r && ctl_r.call);
   ret_cov_c: cover property (@(posedge clk_sys) disable iff (reset) valid_r && ctl_r.reti);
endmodule // fid_decoder
`default_nettype wire

// ---- rtl/fid_map.svh ----
/*
 * Constant map of the 14-bit instruction decoder: opcode fields, field
 * positions, fixed control words and timing counts.
 * Assumes inclusion by bare name from the decoder.
 */
`ifndef FID_MAP_SVH
`define FID_MAP_SVH

// instruction word fields
`define FID_W_TOP_HI      13
`define FID_W_TOP_LO      12
`define FID_W_OP_HI       11
`define FID_W_OP_LO       8
`define FID_W_DEST        7
`define FID_W_FILE_HI     6
`define FID_W_BIT_HI      9
`define FID_W_BIT_LO      7
`define FID_W_JMP_SEL     11
// families
`define FID_TOP_BYTE      2'h0
`define FID_TOP_BIT       2'h1
`define FID_TOP_BRANCH    2'h2
`define FID_TOP_LIT       2'h3
// byte-oriented operation fields
`define FID_OP_MISC       4'h0
`define FID_OP_CLR        4'h1
`define FID_OP_SUB        4'h2
`define FID_OP_DEC        4'h3
`define FID_OP_OR         4'h4
`define FID_OP_AND        4'h5
`define FID_OP_XOR        4'h6
`define FID_OP_ADD        4'h7
`define FID_OP_MOV        4'h8
`define FID_OP_COM        4'h9
`define FID_OP_INC        4'ha
`define FID_OP_DECSZ      4'hb
`define FID_OP_RR         4'hc
`define FID_OP_RL         4'hd
`define FID_OP_SWAP       4'he
`define FID_OP_INCSZ      4'hf
// bit-oriented codes (upper two bits of op field)
`define FID_BIT_CLR       2'h0
`define FID_BIT_SET       2'h1
`define FID_BIT_TSTC      2'h2
`define FID_BIT_TSTS      2'h3
// fixed control words
`define FID_WORD_RET      14'h0008
`define FID_WORD_RETI     14'h0009
`define FID_WORD_SLEEP    14'h0063
`define FID_WORD_WDTCLR   14'h0064
`define FID_NOP_MASK      14'h3f9f
`define FID_NOP_WORD      14'h0000
// file addresses
`define FID_ADDR_TIMER_ZERO_COUNT     7'h01
`define FID_ADDR_PORT_LO  7'h05
`define FID_ADDR_PORT_HI  7'h09
// index of the last of the four phases of an instruction cycle
`define FID_PHASES        2'h3

`endif

// ---- rtl/fid_pkg.sv ----
/*
 * Types of the instruction decoder: ALU operations, flag
 * masks and the decoded control bundle.
 * Needs no include file; only the decoder includes fid_map.svh.
 */
`default_nettype none
package fid_pkg;
   typedef enum logic [3:0] {
      FID_ALU_PASSF = 4'h0, FID_ALU_ADD = 4'h1, FID_ALU_SUBFW = 4'h2, FID_ALU_AND = 4'h3,
      FID_ALU_OR = 4'h4, FID_ALU_XOR = 4'h5, FID_ALU_DEC = 4'h6, FID_ALU_INC = 4'h7,
      FID_ALU_RL = 4'h8, FID_ALU_RR = 4'h9, FID_ALU_COM = 4'ha, FID_ALU_SWAP = 4'hb,
      FID_ALU_ZERO = 4'hc, FID_ALU_PASSW = 4'hd, FID_ALU_BCLR = 4'he, FID_ALU_BSET = 4'hf
   } fid_alu_t;
   typedef struct packed {
      logic c;
      logic dc;
      logic z;
   } fid_flags_t;
   typedef struct packed {
      fid_alu_t   alu;          // operation
      logic       use_lit;      // literal replaces file operand
      logic       wr_acc;       // result to accumulator
      logic       wr_file;      // result to file register
      logic [6:0] file_addr;    // file register address
      logic [2:0] bit_sel;      // bit position
      fid_flags_t flags;        // flags updated
      logic       skip_zero;    // skip when result zero
      logic       skip_bclr;    // skip when tested bit clear
      logic       skip_bset;    // skip when tested bit set
      logic       call;         // push and jump
      logic       jump;         // jump
      logic       ret;          // pop into pc
      logic       reti;         // pop and re-enable interrupts
      logic [10:0] target;      // branch target
      logic       sleep;        // enter standby
      logic       wdt_clr;      // clear watchdog
      logic       pin_read;     // read port pins not latch
      logic       psc_clr;      // clear timer-zero prescaler
      logic       illegal;      // unused encoding, runs as idle
   } fid_ctl_t;
endpackage
`default_nettype wire

// ---- tb/fid_fetch_model.sv ----
/*
 * Fetch and datapath stand-in for the decoder: presents a word in phase 0
 * and the zero and tested-bit answers in phase 3.
 * Assumes the bench sets word, zero and bit values at a falling edge.
 */
`default_nettype none
module fid_fetch_model
(
   input  wire logic        clk_sys,
   input  wire logic [1:0]  phase,
   input  wire logic [13:0] word,
   input  wire logic        rz,
   input  wire logic        tbit,
   output logic             [13:0] instr_word,
   output logic             result_zero,
   output logic             tested_bit
);
   timeunit 1ns;
   timeprecision 1ns;
   // outside their slot the lines carry inverted junk
   assign instr_word  = (phase == 2'h0) ? word : ~word;
   assign result_zero = (phase == 2'h3) ? rz : ~rz;
   assign tested_bit  = (phase == 2'h3) ? tbit : ~tbit;
endmodule // fid_fetch_model
`default_nettype wire

// ---- tb/fourteen_bit_instruction_decoder_tb_top.sv ----
/*
 * Self-checking bench of the instruction decoder, one task per scenario.
 * Assumes fid_pkg and fid_decoder compiled first.
 */
`default_nettype none
module fourteen_bit_instruction_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [13:0] word = 14'h0000;
   logic rz = 1'b0;
   logic tbit = 1'b0;
   logic psc_on_timer = 1'b0;
   logic [13:0] instr_word;
   logic result_zero, tested_bit, ctl_valid, cycle_end, idle_cycle;
   logic [1:0] phase;
   fid_pkg::fid_ctl_t ctl;
   int fail_count = 0;
   int checks_done = 0;
   // clock and units
   always #50 clk_sys = ~clk_sys;
   fid_decoder dut_u (.clk_sys(clk_sys), .reset(reset), .instr_word(instr_word), .result_zero(result_zero),
      .tested_bit(tested_bit), .psc_on_timer(psc_on_timer), .ctl(ctl), .ctl_valid(ctl_valid),
      .phase(phase), .cycle_end(cycle_end), .idle_cycle(idle_cycle));
   fid_fetch_model mem_u (.clk_sys(clk_sys), .phase(phase), .word(word), .rz(rz), .tbit(tbit),
      .instr_word(instr_word), .result_zero(result_zero), .tested_bit(tested_bit));
   // verdict
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
      checks_done++;
      if (e !== s)
      begin
         $display("wrong value %s expected %0h seen %0h", nm, e, s);
         fail_count++;
      end
   endtask
   // present one word, return once its decode stands (phase 2)
   task automatic issue(input logic [13:0] w, input logic z, input logic b);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (phase !== 2'h0 && n < 8)
      begin
         @(negedge clk_sys);
         n++;
      end
      word = w;
      rz = z;
      tbit = b;
      @(negedge clk_sys);
      @(negedge clk_sys);
      chk("phase", 2'h2, phase);
      chk("cycle_end", 1'b0, cycle_end);
   endtask
   // idle word after, checking whether it was discarded
   task automatic nx(input logic v);
      issue(14'h0000, 1'b0, 1'b0);
      chk("ctl_valid", v, ctl_valid);
      chk("idle_cycle", !v, idle_cycle);
      if (!v)
         chk("ctl", '0, ctl);
   endtask
   task automatic t_byte;
      logic [3:0] op [14] = '{4'h7, 4'h5, 4'h4, 4'h6, 4'h2, 4'hd, 4'hc, 4'hb, 4'hf,
         4'h3, 4'h8, 4'h9, 4'ha, 4'he};
      fid_pkg::fid_alu_t al [14] = '{fid_pkg::FID_ALU_ADD, fid_pkg::FID_ALU_AND, fid_pkg::FID_ALU_OR,
         fid_pkg::FID_ALU_XOR, fid_pkg::FID_ALU_SUBFW, fid_pkg::FID_ALU_RL, fid_pkg::FID_ALU_RR,
         fid_pkg::FID_ALU_DEC, fid_pkg::FID_ALU_INC, fid_pkg::FID_ALU_DEC, fid_pkg::FID_ALU_PASSF,
         fid_pkg::FID_ALU_COM, fid_pkg::FID_ALU_INC, fid_pkg::FID_ALU_SWAP};
      logic [2:0] fl [14] = '{3'h7, 3'h1, 3'h1, 3'h1, 3'h7, 3'h4, 3'h4, 3'h0, 3'h0,
         3'h1, 3'h1, 3'h1, 3'h1, 3'h0};
      logic d;
      for (int i = 0; i < 14; i++)
      begin
         d = i[0];
         issue({2'h0, op[i], d, d ? 7'h7f : 7'h00}, 1'b0, 1'b0);
         chk("alu", al[i], ctl.alu);
         chk("flags", fl[i], ctl.flags);
         chk("wr_file", d, ctl.wr_file);
         chk("wr_acc", !d, ctl.wr_acc);
         chk("file_addr", d ? 7'h7f : 7'h00, ctl.file_addr);
         chk("skip_zero", i == 7 || i == 8, ctl.skip_zero);
      end
      $display("byte ops done");
   endtask
   task automatic t_lit;
      logic [3:0] op [7] = '{4'he, 4'hf, 4'h8, 4'h9, 4'ha, 4'hc, 4'hd};
      fid_pkg::fid_alu_t al [7] = '{fid_pkg::FID_ALU_ADD, fid_pkg::FID_ALU_ADD, fid_pkg::FID_ALU_OR,
         fid_pkg::FID_ALU_AND, fid_pkg::FID_ALU_XOR, fid_pkg::FID_ALU_SUBFW, fid_pkg::FID_ALU_SUBFW};
      logic [2:0] fl [7] = '{3'h7, 3'h7, 3'h1, 3'h1, 3'h1, 3'h7, 3'h7};
      for (int i = 0; i < 7; i++)
      begin
         issue({2'h3, op[i], 8'h5a}, 1'b0, 1'b0);
         chk("alu", al[i], ctl.alu);
         chk("flags", fl[i], ctl.flags);
         chk("lit acc", 3'h6, {ctl.use_lit, ctl.wr_acc, ctl.wr_file});
      end
      issue({2'h3, 4'h3, 8'hff}, 1'b0, 1'b0);
      chk("load", 6'h30, {ctl.use_lit, ctl.wr_acc, ctl.flags, ctl.ret});
      nx(1'b1);
      issue({2'h3, 4'h4, 8'h01}, 1'b0, 1'b0);
      chk("return_with_literal acc", 1'b1, ctl.wr_acc);
      nx(1'b0);
      $display("literal ops done");
   endtask
   task automatic t_bit;
      for (int b = 0; b < 8; b += 7)
      begin
         issue({2'h1, 2'h0, b[2:0], 7'h20}, 1'b0, 1'b0);
         chk("bclr", {fid_pkg::FID_ALU_BCLR, b[2:0], 3'h0}, {ctl.alu, ctl.bit_sel, ctl.flags});
         issue({2'h1, 2'h1, b[2:0], 7'h20}, 1'b0, 1'b0);
         chk("bset", {fid_pkg::FID_ALU_BSET, b[2:0], 3'h0}, {ctl.alu, ctl.bit_sel, ctl.flags});
         chk("bit wr_file", 1'b1, ctl.wr_file);
      end
      for (int k = 0; k < 4; k++)
      begin
         issue({2'h1, 1'b1, k[0], 3'h3, 7'h21}, 1'b0, k[1]);
         chk("bit skip", {k[0], !k[0]}, {ctl.skip_bset, ctl.skip_bclr});
         nx(k[0] != k[1]);
      end
      $display("bit ops done");
   endtask
   task automatic t_flow;
      for (int k = 0; k < 4; k++)
      begin
         issue({2'h0, k[0] ? 4'hf : 4'hb, 1'b1, 7'h20}, k[1], 1'b0);
         nx(!k[1]);
      end
      issue({2'h2, 1'b0, 11'h7ff}, 1'b0, 1'b0);
      chk("call", 13'h17ff, {ctl.call, ctl.jump, ctl.target});
      nx(1'b0);
      issue({2'h2, 1'b1, 11'h400}, 1'b0, 1'b0);
      chk("jump", 13'h0c00, {ctl.call, ctl.jump, ctl.target});
      nx(1'b0);
      issue(14'h0008, 1'b0, 1'b0);
      chk("ret", 2'h2, {ctl.ret, ctl.reti});
      nx(1'b0);
      issue(14'h0009, 1'b0, 1'b0);
      chk("reti", 1'b1, ctl.reti);
      nx(1'b0);
      issue(14'h0063, 1'b0, 1'b0);
      chk("sleep", 2'h2, {ctl.sleep, ctl.wdt_clr});
      nx(1'b1);
      issue(14'h0064, 1'b0, 1'b0);
      chk("wdt_clr", 2'h1, {ctl.sleep, ctl.wdt_clr});
      nx(1'b1);
      $display("control ops done");
   endtask
   task automatic t_misc;
      issue({2'h0, 4'h0, 1'b1, 7'h22}, 1'b0, 1'b0);
      chk("store", 2'h1, {ctl.wr_acc, ctl.wr_file});
      issue(14'h0060, 1'b0, 1'b0);
      chk("idle_op", 3'h4, {ctl_valid, ctl.wr_acc, ctl.wr_file});
      issue({2'h0, 4'h1, 1'b0, 7'h00}, 1'b0, 1'b0);
      chk("acc zero", 5'h11, {ctl.wr_acc, ctl.wr_file, ctl.flags});
      issue({2'h0, 4'h1, 1'b1, 7'h30}, 1'b0, 1'b0);
      chk("file zero", 5'h09, {ctl.wr_acc, ctl.wr_file, ctl.flags});
      issue({2'h0, 4'h4, 1'b1, 7'h06}, 1'b0, 1'b0);
      chk("pin_read", 1'b1, ctl.pin_read);
      issue({2'h0, 4'h4, 1'b1, 7'h20}, 1'b0, 1'b0);
      chk("no pin_read", 1'b0, ctl.pin_read);
      for (int k = 0; k < 3; k++)
      begin
         psc_on_timer = k != 2;
         issue({2'h0, 4'h7, k != 1, 7'h01}, 1'b0, 1'b0);
         chk("psc_clr", k == 0, ctl.psc_clr);
      end
      // unused literal field runs as idle; last phase raises cycle_end
      issue({2'h3, 4'hb, 8'h00}, 1'b0, 1'b0);
      chk("illegal", 3'h4, {ctl.illegal, ctl.wr_acc, ctl.flags.z});
      @(negedge clk_sys);
      chk("cycle_end", 1'b1, cycle_end);
      $display("side effects done");
   endtask
   // main sequence
   initial
   begin
      repeat (2) @(negedge clk_sys);
      chk("reset valid", 3'h0, {ctl_valid, phase});
      chk("reset ctl", '0, ctl);
      reset = 1'b0;
      t_byte();
      t_lit();
      t_bit();
      t_flow();
      t_misc();
      end_of_test();
   end
   // hang guard, far beyond the few hundred cycles used
   initial
   begin
      #1000000;
      fail_count++;
      end_of_test();
   end
endmodule // fourteen_bit_instruction_decoder_tb_top
`default_nettype wire
